// file: tsc_pkg.sv
package tsc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_SRC       = 4;
  localparam int NUM_LANE      = 4;
  localparam int NUM_IN_CH     = NUM_SRC * NUM_LANE;
  localparam int NUM_BOOST_CH  = 8;
  localparam int ADDR_LOW_W    = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int TERM_PULSE_MS  = 100;
  localparam int TERM_PULSE_CYC = TERM_PULSE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------
  // Serial defaults
  // ----------------------------------------
  localparam logic [NUM_IN_CH-1:0]    PULSE_EN_RST = 16'h0000;
  localparam logic                    TERM_OFF_RST = 1'h0;
  localparam logic [NUM_BOOST_CH-1:0] BOOST_RST    = 8'h00;
  localparam logic [1:0]              SRC_RST      = 2'h0;
  localparam logic [1:0]              PE_RST       = 2'h0;
  localparam logic                    EN_RST       = 1'h1;

  typedef enum logic [1:0] {
    TSC_PIN_CTRL    = 2'h1,
    TSC_SERIAL_CTRL = 2'h2
  } tsc_mode_t;

  // Serial register image, written whole by the serial slave
  typedef struct packed {
    logic [NUM_IN_CH-1:0]    pulseEn;
    logic                    termOff;
    logic [NUM_BOOST_CH-1:0] boost;
    logic [1:0]              src;
    logic                    outTerm;
    logic                    curSel;
    logic [1:0]              preEmph;
    logic                    outEn;
  } tsc_cfg_t;

  // Parallel pin bundle
  typedef struct packed {
    logic [1:0] src;
    logic       boost;
    logic       outTerm;
    logic       curSel;
    logic [1:0] preEmph;
    logic       outEn;
  } tsc_pins_t;

endpackage

// file: tsc_term_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_term_timer #(
  parameter int CYCLES = tsc_pkg::TERM_PULSE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic start,
  output var  logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("CYCLES must be at least one");
  end

  logic [CW-1:0] count_r;

  // ----------------------------------------
  // Countdown; a new switch restarts it
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (start) begin
      count_r <= CW'(CYCLES);
    end else if (count_r != '0) begin
      count_r <= count_r - CW'(1);
    end
  end

  assign busy = (count_r != '0);
endmodule // tsc_term_timer
`default_nettype wire

// file: tsc_config_control.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_config_control #(
  parameter int UPDATE_CYC = 4,
  parameter int PULSE_CYC  = tsc_pkg::TERM_PULSE_CYC
) (
  input  wire logic                           sys_clk,
  input  wire logic                           srst,
  input  wire logic [tsc_pkg::ADDR_LOW_W-1:0] busAddrLow,
  input  wire logic [tsc_pkg::ADDR_LOW_W-1:0] accessAddrLow,
  input  wire logic                           serialAccess,
  input  wire logic                           serialWrite,
  input  wire tsc_pkg::tsc_cfg_t              serialCfg,
  input  wire tsc_pkg::tsc_pins_t             pins,
  output var  logic                           addrMatch,
  output var  logic                           serialMode,
  output var  logic [1:0]                     sourceSel,
  output var  logic [tsc_pkg::NUM_IN_CH-1:0]  inputTermOn,
  output var  logic [tsc_pkg::NUM_BOOST_CH-1:0] boostHigh,
  output var  logic                           outputTermOn,
  output var  logic                           currentHigh,
  output var  logic [1:0]                     preEmphLevel,
  output var  logic                           outputEnable,
  output var  logic                           updatePending
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (UPDATE_CYC < 1) begin : g_bad_update
    $error("UPDATE_CYC must be at least one");
  end
  if (PULSE_CYC < 1) begin : g_bad_pulse
    $error("PULSE_CYC must be at least one");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int UW = $clog2(UPDATE_CYC + 1);

  tsc_pkg::tsc_mode_t mode_r;
  tsc_pkg::tsc_cfg_t  serCfg_r;
  tsc_pkg::tsc_cfg_t  target;
  tsc_pkg::tsc_cfg_t  applied_r;
  logic               rstSeen_r;
  logic [UW-1:0]      win_r;
  logic               termBusy;
  logic               srcChange;

  // ----------------------------------------
  // Pin image
  // ----------------------------------------
  // Pin image expanded to the full setting; input terminations forced on
  function automatic tsc_pkg::tsc_cfg_t pin_cfg(input tsc_pkg::tsc_pins_t p);
    tsc_pkg::tsc_cfg_t c;
    c.pulseEn = '0;
    c.termOff = 1'b0;
    c.boost   = {tsc_pkg::NUM_BOOST_CH{p.boost}};
    c.src     = p.src;
    c.outTerm = p.outTerm;
    c.curSel  = p.curSel;
    c.preEmph = p.preEmph;
    c.outEn   = p.outEn;
    return c;
  endfunction

  // ----------------------------------------
  // Control mode and serial image
  // ----------------------------------------
  // Any addressed access, read or write, takes control until reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= tsc_pkg::TSC_PIN_CTRL;
    end else if (serialAccess && addrMatch) begin
      mode_r <= tsc_pkg::TSC_SERIAL_CTRL;
    end
  end

  // Strapped fields caught on the first edge after reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rstSeen_r <= 1'b1;
    end else begin
      rstSeen_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serCfg_r.pulseEn <= tsc_pkg::PULSE_EN_RST;
      serCfg_r.termOff <= tsc_pkg::TERM_OFF_RST;
      serCfg_r.boost   <= tsc_pkg::BOOST_RST;
      serCfg_r.src     <= tsc_pkg::SRC_RST;
      serCfg_r.outTerm <= 1'b0;
      serCfg_r.curSel  <= 1'b0;
      serCfg_r.preEmph <= tsc_pkg::PE_RST;
      serCfg_r.outEn   <= tsc_pkg::EN_RST;
    end else if (serialWrite && addrMatch) begin
      serCfg_r <= serialCfg;
    end else if (rstSeen_r) begin
      serCfg_r.outTerm <= pins.outTerm;
      serCfg_r.curSel  <= pins.curSel;
    end
  end

  always_comb begin
    if (mode_r == tsc_pkg::TSC_SERIAL_CTRL) begin
      target = serCfg_r;
    end else begin
      target = pin_cfg(pins);
    end
  end

  // ----------------------------------------
  // Update window
  // ----------------------------------------
  // Window is not restarted by new values; latest wins at its end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      win_r <= '0;
    end else if (win_r != '0) begin
      win_r <= win_r - UW'(1);
    end else if (target != applied_r) begin
      win_r <= UW'(UPDATE_CYC);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      applied_r.pulseEn <= tsc_pkg::PULSE_EN_RST;
      applied_r.termOff <= tsc_pkg::TERM_OFF_RST;
      applied_r.boost   <= tsc_pkg::BOOST_RST;
      applied_r.src     <= tsc_pkg::SRC_RST;
      applied_r.outTerm <= 1'b0;
      applied_r.curSel  <= 1'b0;
      applied_r.preEmph <= tsc_pkg::PE_RST;
      applied_r.outEn   <= tsc_pkg::EN_RST;
    end else if (win_r == '0 && target != applied_r) begin
      applied_r <= target;
    end
  end

  // ----------------------------------------
  // Source switch timer
  // ----------------------------------------
  // Each switch restarts the count, so quick switches stretch the gap
  assign srcChange = (win_r == '0) && (target.src != applied_r.src);

  tsc_term_timer #(
    .CYCLES (PULSE_CYC)
  ) u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .start   (srcChange),
    .busy    (termBusy)
  );

  // ----------------------------------------
  // Address match
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addrMatch <= 1'b0;
    end else begin
      addrMatch <= (accessAddrLow == busAddrLow);
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serialMode    <= 1'b0;
      sourceSel     <= tsc_pkg::SRC_RST;
      inputTermOn   <= '1;
      boostHigh     <= tsc_pkg::BOOST_RST;
      outputTermOn  <= 1'b0;
      currentHigh   <= 1'b0;
      preEmphLevel  <= tsc_pkg::PE_RST;
      outputEnable  <= tsc_pkg::EN_RST;
      updatePending <= 1'b0;
    end else begin
      serialMode    <= (mode_r == tsc_pkg::TSC_SERIAL_CTRL);
      sourceSel     <= applied_r.src;
      // Own mask bit per channel; the clock may ride any lane
      for (int i = 0; i < tsc_pkg::NUM_IN_CH; i++) begin
        inputTermOn[i] <= !(applied_r.termOff ||
                            (applied_r.pulseEn[i] && termBusy));
      end
      boostHigh     <= applied_r.boost;
      outputTermOn  <= applied_r.outTerm;
      currentHigh   <= applied_r.curSel;
      preEmphLevel  <= applied_r.preEmph;
      outputEnable  <= applied_r.outEn;
      updatePending <= (win_r != '0);
    end
  end
endmodule // tsc_config_control
`default_nettype wire

// file: tsc_config_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_config_control_sva (
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic [2:0]         busAddrLow,
  input wire logic [2:0]         accessAddrLow,
  input wire logic               serialAccess,
  input wire tsc_pkg::tsc_pins_t pins,
  input wire logic               addrMatch,
  input wire logic               serialMode,
  input wire logic [15:0]        inputTermOn,
  input wire logic [7:0]         boostHigh,
  input wire logic               outputTermOn,
  input wire logic               currentHigh,
  input wire logic [1:0]         preEmphLevel,
  input wire logic               outputEnable,
  input wire logic               updatePending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_LOCK: assert property (serialMode |=> serialMode)
    else $error("serial mode dropped");
  AST_TAKE: assert property (serialAccess && addrMatch |-> ##2 serialMode)
    else $error("serial mode not entered");
  AST_NO_TAKE: assert property ((!(serialAccess && addrMatch))[*2] ##0 !serialMode |=> !serialMode)
    else $error("serial mode without access");
  AST_HIT: assert property (accessAddrLow == busAddrLow |=> addrMatch)
    else $error("address hit missed");
  AST_MISS: assert property (accessAddrLow != busAddrLow |=> !addrMatch)
    else $error("address miss matched");
  AST_PIN_TERM: assert property (!serialMode |-> &inputTermOn)
    else $error("termination off under pins");
  AST_PIN_FOLLOW: assert property ((!serialMode && pins == $past(pins))[*8] |->
    boostHigh == {8{pins.boost}} && outputTermOn == pins.outTerm && currentHigh == pins.curSel &&
    preEmphLevel == pins.preEmph && outputEnable == pins.outEn) else $error("outputs ignore pins");
  AST_HOLD: assert property (updatePending && $past(updatePending) |-> $stable(boostHigh))
    else $error("boost changed inside window");
  AST_RESET: assert property (disable iff (1'b0) srst |=> !serialMode && !addrMatch && &inputTermOn &&
    boostHigh == 8'h00 && !outputTermOn && !currentHigh && preEmphLevel == 2'h0 && outputEnable)
    else $error("reset values wrong");
endmodule // tsc_config_control_sva
bind tsc_config_control tsc_config_control_sva u_sva (.sys_clk(sys_clk), .srst(srst), .busAddrLow(busAddrLow),
  .accessAddrLow(accessAddrLow), .serialAccess(serialAccess), .pins(pins), .addrMatch(addrMatch),
  .serialMode(serialMode), .inputTermOn(inputTermOn), .boostHigh(boostHigh), .outputTermOn(outputTermOn),
  .currentHigh(currentHigh), .preEmphLevel(preEmphLevel), .outputEnable(outputEnable),
  .updatePending(updatePending));
`default_nettype wire

// file: tsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
  input  wire logic              sys_clk,
  input  wire logic              req,
  input  wire logic              extTerm,
  input  wire logic              rdOnly,
  input  wire tsc_pkg::tsc_cfg_t cfgIn,
  output var  logic              serialAccess,
  output var  logic              serialWrite,
  output var  tsc_pkg::tsc_cfg_t serialCfg,
  output var  tsc_pkg::tsc_cfg_t sentCfg
);
  tsc_pkg::tsc_cfg_t fixed;
  always_comb begin
    fixed = cfgIn;
    fixed.curSel = cfgIn.outTerm;
    if (!cfgIn.outTerm && !extTerm) fixed.outEn = 1'b0;
  end
  // Image toggles outside the strobe so a stale value never looks valid
  always_ff @(posedge sys_clk) begin
    serialAccess <= req;
    serialWrite  <= req && !rdOnly;
    serialCfg    <= (req && !rdOnly) ? fixed : ~serialCfg;
    if (req && !rdOnly) sentCfg <= fixed;
  end
endmodule // tsc_host_model
`default_nettype wire

// file: tsc_config_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_config_control_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int PULSE = 20;
  logic               sys_clk = 1'b0, srst = 1'b1, req = 1'b0, ext = 1'b1, rd = 1'b0;
  logic [2:0]         busAddrLow = 3'h5, accessAddrLow = 3'h0;
  logic               serialAccess, serialWrite, addrMatch, serialMode, outputTermOn, currentHigh;
  logic               outputEnable, updatePending;
  tsc_pkg::tsc_cfg_t  cfgIn = '0, serialCfg, sentCfg;
  tsc_pkg::tsc_pins_t pins = '0;
  logic [1:0]         sourceSel, preEmphLevel;
  logic [15:0]        inputTermOn;
  logic [7:0]         boostHigh;
  int                 mismatches = 0, n_tests = 0, i;
  always #2 sys_clk = ~sys_clk;
  tsc_config_control #(.UPDATE_CYC(4), .PULSE_CYC(PULSE)) dut (.sys_clk(sys_clk), .srst(srst),
    .busAddrLow(busAddrLow), .accessAddrLow(accessAddrLow), .serialAccess(serialAccess), .serialWrite(serialWrite),
    .serialCfg(serialCfg), .pins(pins), .addrMatch(addrMatch), .serialMode(serialMode), .sourceSel(sourceSel),
    .inputTermOn(inputTermOn), .boostHigh(boostHigh), .outputTermOn(outputTermOn), .currentHigh(currentHigh),
    .preEmphLevel(preEmphLevel), .outputEnable(outputEnable), .updatePending(updatePending));
  tsc_host_model host (.sys_clk(sys_clk), .req(req), .extTerm(ext), .cfgIn(cfgIn), .serialAccess(serialAccess),
    .rdOnly(rd), .serialWrite(serialWrite), .serialCfg(serialCfg), .sentCfg(sentCfg));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Connected terminations: global off drops all, pulse drops the enabled ones
  function automatic logic [15:0] exp_term(input logic off, input logic [15:0] pulse, input logic busy);
    return ~({16{off}} | (pulse & {16{busy}}));
  endfunction
  task automatic write1(input tsc_pkg::tsc_cfg_t c);
    cfgIn <= c;
    req <= 1'b1;
    tick(1);
    req <= 1'b0;
  endtask
  // Waits out the update window, then the pulse interval
  task automatic check_cfg();
    int k;
    tick(3);
    for (k = 0; k < 50 && updatePending !== 1'b0; k++) tick(1);
    if (k == 50) begin
      $display("unexpected at %0t: window never closed", $time);
      mismatches++;
      complete_run();
    end
    tick(PULSE + 2);
    check(32'(serialMode), 32'h1);
    check(32'(boostHigh), 32'(sentCfg.boost));
    check(32'(sourceSel), 32'(sentCfg.src));
    check(32'(inputTermOn), 32'(exp_term(sentCfg.termOff, sentCfg.pulseEn, 1'b0)));
    check(32'(outputTermOn), 32'(sentCfg.outTerm));
    check(32'(currentHigh), 32'(sentCfg.curSel));
    check(32'(outputEnable), 32'(sentCfg.outEn));
    check(32'(preEmphLevel), 32'(sentCfg.preEmph));
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hEA1C6274));
    tick(12);
    srst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      pins <= (i == 0) ? 8'hFF : 8'($urandom);
      busAddrLow <= 3'($urandom);
      tick(2);
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      tick(12);
      check(32'(sourceSel), 32'(pins.src));
      check(32'(boostHigh), 32'({8{pins.boost}}));
      check(32'(inputTermOn), 32'hFFFF);
      check(32'(outputTermOn), 32'(pins.outTerm));
      check(32'(currentHigh), 32'(pins.curSel));
      check(32'({preEmphLevel, outputEnable}), 32'({pins.preEmph, pins.outEn}));
    end
    accessAddrLow <= busAddrLow + 3'h1;
    tick(2);
    write1(32'($urandom));
    tick(4);
    check(32'(serialMode), 32'h0);
    accessAddrLow <= busAddrLow;
    tick(2);
    for (i = 0; i < 6; i++) begin
      ext <= (i == 1) ? 1'b0 : 1'($urandom);
      write1((i == 0) ? 32'hFFFFFFFF : 32'($urandom));
      pins <= 8'($urandom);
      check_cfg();
    end
    cfgIn <= 32'($urandom);
    req <= 1'b1;
    tick(1);
    cfgIn <= 32'($urandom);
    tick(1);
    req <= 1'b0;
    check_cfg();
    write1({16'hA5C3, 1'b0, 8'h00, ~sentCfg.src, 5'h00});
    tick(6);
    check(32'(inputTermOn), 32'(exp_term(1'b0, 16'hA5C3, 1'b1)));
    tick(PULSE - 3);
    check(32'(inputTermOn), 32'(exp_term(1'b0, 16'hA5C3, 1'b1)));
    tick(1);
    check(32'(inputTermOn), 32'(exp_term(1'b0, 16'hA5C3, 1'b0)));
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(12);
    check(32'(serialMode), 32'h0);
    check(32'(boostHigh), 32'({8{pins.boost}}));
    // Access without a write: the serial image keeps its reset values and strapped outTerm/curSel
    rd <= 1'b1;
    req <= 1'b1;
    tick(1);
    req <= 1'b0;
    rd <= 1'b0;
    tick(6);
    pins <= ~pins;
    tick(8);
    check(32'(serialMode), 32'h1);
    check(32'(boostHigh), 32'(tsc_pkg::BOOST_RST));
    check(32'({outputTermOn, currentHigh}), 32'({~pins.outTerm, ~pins.curSel}));
    complete_run();
  end
endmodule // tsc_config_control_tb_top
`default_nettype wire
